// ==== rtl/lcd_ctrl_pkg.sv ====
// package: register map, field positions and codes of the lcd segment driver control
package lcd_ctrl_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_PORT_CTRL = 16'hffc0;
  localparam logic [15:0] ADDR_CTRL = 16'hffc1;
  localparam logic [15:0] ADDR_WAVE_SUPPLY = 16'hffc2;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DUTY_HI_BIT = 7;
  localparam int DUTY_LO_BIT = 6;
  localparam int MIRROR_BIT = 5;
  localparam int EXPAND_BIT = 4;
  localparam int POWER_BIT = 6;
  localparam int RUN_BIT = 5;
  localparam int SHOW_BIT = 4;
  localparam int WAVE_BIT = 7;
  localparam int SUPPLY_BIT = 4;
  // ---------------------------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT_CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] WAVE_SUPPLY_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h7f;
  localparam logic [7:0] WAVE_SUPPLY_MASK = 8'h9f;
  localparam int NUM_SEG = 32;
  localparam int NUM_COM = 4;
  localparam int NUM_EXP = 4;
  // ---------------------------------------------------------------
  // duty codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DUTY_STATIC = 2'b00,
    DUTY_HALF = 2'b01,
    DUTY_THIRD = 2'b10,
    DUTY_QUARTER = 2'b11
  } duty_t;
endpackage

// ==== rtl/lcd_cfg_if.sv ====
// interface: decoded configuration from register file to pin mux
`timescale 1ns/1ns
interface lcd_cfg_if;
  logic [1:0] duty;
  logic mirror;
  logic expand;
  logic [3:0] range;
  logic show;
  logic run;
  modport src (output duty, mirror, expand, range, show, run);
  modport dst (input duty, mirror, expand, range, show, run);
endinterface

// ==== rtl/lcd_pin_mux.sv ====
// pin mux: segment/port/expansion assignment, common mirroring, blanking
`timescale 1ns/1ns
module lcd_pin_mux
  import lcd_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  lcd_cfg_if.dst cfg,
  // raw drive from the waveform engine
  input wire logic [NUM_SEG-1:0] segRaw,
  input wire logic [NUM_COM-1:0] comRaw,
  input wire logic [NUM_EXP-1:0] expRaw,
  // pin results
  output logic [NUM_SEG-1:0] segIsDrive,
  output logic [NUM_SEG-1:0] segOut,
  output logic [NUM_COM-1:0] commonPin
);
  typedef struct packed {
    logic [NUM_SEG-1:0] isDrive;
    logic [NUM_SEG-1:0] seg;
    logic [NUM_COM-1:0] com;
  } mux_state_t;
  mux_state_t stateReg, stateNext;

  // mask of top pins driven as segments for a range code
  function automatic logic [NUM_SEG-1:0] range_mask(input logic [3:0] r);
    if (r[3]) begin
      range_mask = 32'hffffffff;
    end else if (r[2:1] == 2'b11) begin
      range_mask = 32'hffffff00;
    end else if (r[2:1] == 2'b10) begin
      range_mask = 32'hffff0000;
    end else if (r[2:1] == 2'b01) begin
      range_mask = 32'hff000000;
    end else begin
      range_mask = 32'h00000000;
    end
  endfunction

  // used commons per duty: static uses 1, quarter uses all 4
  function automatic logic [NUM_COM-1:0] com_used(input logic [1:0] d);
    case (d)
      DUTY_STATIC: com_used = 4'h1;
      DUTY_HALF: com_used = 4'h3;
      DUTY_THIRD: com_used = 4'h7;
      default: com_used = 4'hf;
    endcase
  endfunction

  // decode pins; stopped controller drives all segments and commons low
  always_comb begin
    logic [NUM_SEG-1:0] m;
    logic [NUM_COM-1:0] u;
    m = range_mask(cfg.range);
    u = com_used(cfg.duty);
    stateNext = stateReg;
    stateNext.isDrive = cfg.expand ? 32'hf0000000 : m;
    stateNext.seg = (cfg.show ? segRaw : '0) & m;
    if (cfg.expand) begin
      stateNext.seg = {expRaw, 28'h0000000};
    end
    for (int i = 0; i < NUM_COM; i++) begin
      if (u[i]) begin
        stateNext.com[i] = comRaw[i];
      end else begin
        stateNext.com[i] = cfg.mirror ? comRaw[0] : 1'b0;
      end
    end
    if (!cfg.run) begin
      stateNext.seg = '0;
      stateNext.com = '0;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign segIsDrive = stateReg.isDrive;
  assign segOut = stateReg.seg;
  assign commonPin = stateReg.com;

  mirror_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.run && cfg.mirror && cfg.duty == DUTY_STATIC) |=> commonPin[3] == commonPin[0])
    else $error("unused common not mirrored");
  no_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.run && !cfg.mirror && cfg.duty == DUTY_HALF) |=> commonPin[3:2] == 2'b00)
    else $error("unused common driven without mirror");
  range_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg.expand && cfg.range[3:1] == 3'b010) |=> segIsDrive == 32'hffff0000)
    else $error("segment range wrong");
  expand_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.expand |=> segIsDrive == 32'hf0000000)
    else $error("expansion map wrong");
  blank_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg.show && !cfg.expand) |=> segOut == 32'h00000000)
    else $error("blank not blank");
endmodule // lcd_pin_mux

// ==== rtl/lcd_segment_driver_control.sv ====
// top: avalon register file and power gating of the lcd segment driver control
`timescale 1ns/1ns
module lcd_segment_driver_control
  import lcd_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // chip state
  input wire logic standby,
  // waveform engine inputs
  input wire logic [NUM_SEG-1:0] segRaw,
  input wire logic [NUM_COM-1:0] comRaw,
  input wire logic [NUM_EXP-1:0] expRaw,
  // pins and supply controls
  output logic [NUM_SEG-1:0] segIsDrive,
  output logic [NUM_SEG-1:0] segOut,
  output logic [NUM_COM-1:0] commonPin,
  output logic drivePowerEnable,
  output logic stepUpRun,
  output logic waveformB,
  output logic [3:0] frameClockSelect
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] portCtrl;
    logic [7:0] ctrl;
    logic [7:0] waveSupply;
    logic ack;
    logic [31:0] rdata;
    logic power;
  } top_state_t;
  top_state_t stateReg, stateNext;
  lcd_cfg_if cfg();
  logic req;

  // one wait state: request answered on the second edge
  assign req = read | write;
  assign waitrequest = req & ~stateReg.ack;

  // register file and power gating
  always_comb begin
    stateNext = stateReg;
    stateNext.ack = req & ~stateReg.ack;
    if (req && !stateReg.ack) begin
      if (write) begin
        if (address == ADDR_PORT_CTRL) begin
          stateNext.portCtrl = writedata[7:0];
        end else if (address == ADDR_CTRL) begin
          stateNext.ctrl = writedata[7:0] & CTRL_MASK;
        end else if (address == ADDR_WAVE_SUPPLY) begin
          stateNext.waveSupply = writedata[7:0] & WAVE_SUPPLY_MASK;
        end
      end else begin
        if (address == ADDR_PORT_CTRL) begin
          stateNext.rdata = {24'h000000, stateReg.portCtrl};
        end else if (address == ADDR_CTRL) begin
          stateNext.rdata = {24'h000000, stateReg.ctrl};
        end else if (address == ADDR_WAVE_SUPPLY) begin
          stateNext.rdata = {24'h000000, stateReg.waveSupply};
        end else begin
          stateNext.rdata = 32'h00000000; // unmapped reads zero
        end
      end
    end
    // stop keeps every register; the supply is gated here, segments and commons in the pin mux
    stateNext.power = stateReg.ctrl[POWER_BIT] & stateReg.ctrl[RUN_BIT] & ~standby;
  end

  // single state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg <= '{portCtrl: PORT_CTRL_RESET, ctrl: CTRL_RESET,
                    waveSupply: WAVE_SUPPLY_RESET, ack: 1'b0,
                    rdata: 32'h00000000, power: 1'b0};
    end else begin
      stateReg <= stateNext;
    end
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  assign readdata = stateReg.rdata;
  assign cfg.duty = stateReg.portCtrl[DUTY_HI_BIT:DUTY_LO_BIT];
  assign cfg.mirror = stateReg.portCtrl[MIRROR_BIT];
  assign cfg.expand = stateReg.portCtrl[EXPAND_BIT];
  // nonzero range with expansion is illegal; expansion wins here
  assign cfg.range = stateReg.portCtrl[3:0];
  assign cfg.show = stateReg.ctrl[SHOW_BIT];
  assign cfg.run = stateReg.ctrl[RUN_BIT];
  assign drivePowerEnable = stateReg.power;
  assign stepUpRun = stateReg.waveSupply[SUPPLY_BIT];
  assign waveformB = stateReg.waveSupply[WAVE_BIT];
  assign frameClockSelect = stateReg.ctrl[3:0];

  lcd_pin_mux mux (
    .clk(clk),
    .rst_n(rst_n),
    .cfg(cfg.src),
    .segRaw(segRaw),
    .comRaw(comRaw),
    .expRaw(expRaw),
    .segIsDrive(segIsDrive),
    .segOut(segOut),
    .commonPin(commonPin)
  );

  sequence write_ctrl_s;
    write && !waitrequest && address == ADDR_CTRL;
  endsequence
  power_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!stateReg.ctrl[RUN_BIT] || standby) |=> !drivePowerEnable)
    else $error("supply on while stopped or standby");
  power_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    (stateReg.ctrl[POWER_BIT] && stateReg.ctrl[RUN_BIT] && !standby) |=> drivePowerEnable)
    else $error("supply not on");
  ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    write_ctrl_s |=> stateReg.ctrl == ($past(writedata[7:0]) & CTRL_MASK))
    else $error("control write lost");
  readback_a: assert property (@(posedge clk) disable iff (!rst_n)
    (read && waitrequest && address == ADDR_PORT_CTRL) |=> readdata[7:0] == stateReg.portCtrl)
    else $error("readback wrong");
  wait_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && waitrequest) |=> !waitrequest)
    else $error("wait longer than one");
  stepup_a: assert property (@(posedge clk) disable iff (!rst_n)
    (write && !waitrequest && address == ADDR_WAVE_SUPPLY) |=>
      (stepUpRun == $past(writedata[SUPPLY_BIT]) && waveformB == $past(writedata[WAVE_BIT])))
    else $error("supply select mismatch");
endmodule // lcd_segment_driver_control

// ==== dv/lcd_panel_model.sv ====
// partner: lcd glass that lights driven segments while its supply is on
`timescale 1ns/1ns
module lcd_panel_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins from the controller
  input wire logic [31:0] segIsDrive,
  input wire logic [31:0] segOut,
  input wire logic [3:0] commonPin,
  input wire logic drivePowerEnable,
  // what the glass shows
  output logic [31:0] litSeg
);
  // glass holds nothing without supply, so an unpowered panel reads dark
  always_ff @(posedge clk) begin
    if (!rst_n || !drivePowerEnable) begin
      litSeg <= 32'h0;
    end else if (|commonPin) begin
      litSeg <= segOut & segIsDrive;
    end
  end
endmodule // lcd_panel_model

// ==== dv/tb_top.sv ====
// testbench: corner and random programming of the lcd segment driver control
`timescale 1ns/1ns
module tb_top
  import lcd_ctrl_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] address = 16'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic standby = 1'b0;
  logic [31:0] segRaw = 32'h0;
  logic [3:0] comRaw = 4'h0;
  logic [3:0] expRaw = 4'h0;
  logic [31:0] readdata, segIsDrive, segOut, litSeg;
  logic [3:0] commonPin, frameClockSelect;
  logic waitrequest, drivePowerEnable, stepUpRun, waveformB;
  logic [31:0] lfsrState = 32'h218c;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // ---------------------------------------------------------------
  // design, panel and clock
  // ---------------------------------------------------------------
  lcd_segment_driver_control u_lcd_segment_driver_control (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .standby(standby),
    .segRaw(segRaw), .comRaw(comRaw), .expRaw(expRaw), .segIsDrive(segIsDrive),
    .segOut(segOut), .commonPin(commonPin), .drivePowerEnable(drivePowerEnable),
    .stepUpRun(stepUpRun), .waveformB(waveformB), .frameClockSelect(frameClockSelect));
  lcd_panel_model u_lcd_panel_model (.clk(clk), .rst_n(rst_n), .segIsDrive(segIsDrive),
    .segOut(segOut), .commonPin(commonPin), .drivePowerEnable(drivePowerEnable),
    .litSeg(litSeg));
  initial begin
    forever #5 clk = ~clk;
  end
  // hang guard: the whole run needs well under 3000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      test_done();
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState;
  endfunction
  function automatic logic [31:0] driveMap(logic [7:0] p);
    if (p[EXPAND_BIT]) return 32'hf000_0000;
    if (p[3]) return 32'hffff_ffff;
    return ~(32'hffff_ffff >> (8 * p[2:1]));
  endfunction
  // used commons follow their own waveform, unused ones copy common 0 or idle low
  function automatic logic [3:0] comExp(logic [7:0] p, logic [7:0] c);
    logic [3:0] e;
    e = 4'h0;
    for (int k = 0; k < 4; k++) begin
      if (c[RUN_BIT]) e[k] = (k <= p[7:6]) ? comRaw[k] : (p[MIRROR_BIT] & comRaw[0]);
    end
    return e;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     output logic [31:0] got);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    // waitrequest and readdata are read at the edge itself, before it updates them
    do @(posedge clk); while (waitrequest !== 1'b0);
    got = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] p, c, w;
    logic [31:0] got, m;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b1, 16'hffc3, 8'hff, got);
    for (int a = 0; a < 4; a++) begin
      bus(1'b0, 16'hffc0 + 16'(a), 8'h0, got);
      chk(got, 32'h0);
    end
    // corners first: every duty and range code, then expansion, then random
    for (int i = 0; i < 48; i++) begin
      p = (i < 8) ? {i[1:0], i[2], 1'b0, i[2:0], 1'b0} : (i == 8) ? 8'hd0 : 8'(lfsr());
      if (p[EXPAND_BIT]) p[3:0] = 4'h0;
      c = (i < 9) ? (8'h70 | 8'(i)) : 8'(lfsr());
      w = 8'(lfsr());
      if (i == 9) c[POWER_BIT] = 1'b0;
      if (i == 9) w[SUPPLY_BIT] = 1'b0;
      got = lfsr();
      standby <= (i > 9) & got[0];
      segRaw <= lfsr();
      comRaw <= 4'(lfsr());
      expRaw <= 4'(lfsr());
      bus(1'b1, ADDR_PORT_CTRL, p, got);
      bus(1'b1, ADDR_CTRL, c, got);
      bus(1'b1, ADDR_WAVE_SUPPLY, w, got);
      bus(1'b0, ADDR_PORT_CTRL, 8'h0, got);
      chk(got, {24'h0, p});
      bus(1'b0, ADDR_CTRL, 8'h0, got);
      chk(got, {24'h0, c & CTRL_MASK});
      bus(1'b0, ADDR_WAVE_SUPPLY, 8'h0, got);
      chk(got, {24'h0, w & WAVE_SUPPLY_MASK});
      repeat (2) @(posedge clk);
      m = driveMap(p);
      if (c[RUN_BIT]) chk(segIsDrive, driveMap(p));
      got = (c[RUN_BIT] & c[SHOW_BIT]) ? (driveMap(p) & segRaw) : 32'h0;
      if (p[EXPAND_BIT]) got[31:28] = c[RUN_BIT] ? expRaw : 4'h0;
      chk(segOut, got);
      if (drivePowerEnable === 1'b1 && |commonPin) chk(litSeg, got & m);
      chk({28'h0, commonPin}, {28'h0, comExp(p, c)});
      chk({31'h0, drivePowerEnable}, {31'h0, c[POWER_BIT] & c[RUN_BIT] & !standby});
      chk({waveformB, stepUpRun, frameClockSelect}, {w[WAVE_BIT], w[SUPPLY_BIT], c[3:0]});
    end
    test_done();
  end
endmodule // tb_top
